// ---- hw/shc_pkg.sv ----
/*
 * Shared constants for the serial host control port: frame layout,
 * device register map, host controller register map and timing.
 * Assumes a single 25 MHz system clock on both ends.
 */
package shc_pkg;
    // ********************************
    // Frame layout
    // ********************************
    localparam int FRAME_CLKS = 16;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int RW_POS = 0;
    localparam int ADDR_LSB_POS = 1;
    localparam int DUMMY_POS = 7;
    localparam int DATA_LSB_POS = 8;
    localparam int FIRST_READ_FALL = 8;
    localparam int LAST_READ_FALL = 15;
    localparam int FIRST_READ_RISE = 9;
    localparam logic RW_READ = 1'b1;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_MHZ = 25;
    localparam int RESET_MIN_NS = 10_000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_PULSE_CYC = RESET_MIN_CYC + 4;
    localparam int SCLK_HALF_CYC = 4;

    // ********************************
    // Device registers
    // ********************************
    localparam logic [5:0] REG_LOOP_CTRL = 6'h00;
    localparam logic [5:0] REG_ALARM_STATUS = 6'h01;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam int LC_SERIAL_REMOTE = 0;
    localparam int LC_PARALLEL_REMOTE = 1;
    localparam int LC_DIGITAL_LOCAL = 2;
    localparam int LC_DEJITTER = 3;
    localparam int LC_DIRECT = 4;
    localparam int LC_DIV32 = 5;

    // ********************************
    // Datapath select codes
    // ********************************
    localparam logic [1:0] TXSRC_NORMAL = 2'h0;
    localparam logic [1:0] TXSRC_RX_SERIAL = 2'h1;
    localparam logic [1:0] TXSRC_RECOVERED_PAR = 2'h2;
    localparam logic [1:0] REF_EXTERNAL = 2'h0;
    localparam logic [1:0] REF_REC_DIV16 = 2'h1;
    localparam logic [1:0] REF_REC_DIV32 = 2'h2;

    // ********************************
    // Host controller registers (byte addresses)
    // ********************************
    localparam logic [3:0] AV_CMD = 4'h0;
    localparam logic [3:0] AV_STATUS = 4'h4;
    localparam logic [3:0] AV_RESET = 4'h8;
    localparam int CMD_WDATA_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_READ_BIT = 16;
    localparam int ST_BUSY = 0;
    localparam int ST_INT = 1;
    localparam int ST_RDATA_LSB = 8;
endpackage

// ---- hw/shc_if.sv ----
/*
 * Pins between the serial controller (host) and the transceiver control
 * port (dev). Resolves the open-drain interrupt line with a pull-up.
 */
`timescale 1ns/1ps
interface shc_if;
    logic chip_sel_n;
    logic ser_clk;
    logic serial_write;
    logic serial_read;
    logic master_reset_n;
    logic int_oe;
    logic int_n;

    // External pull-up: line is low only while the device drives it
    assign int_n = ~int_oe;

    modport dev (
        input chip_sel_n,
        input ser_clk,
        input serial_write,
        input master_reset_n,
        output serial_read,
        output int_oe
    );

    modport host (
        output chip_sel_n,
        output ser_clk,
        output serial_write,
        output master_reset_n,
        input serial_read,
        input int_n
    );
endinterface

// ---- hw/shc_tick_div.sv ----
/*
 * Clock-enable divider: one-cycle tick every DIV clocks.
 * Assumes a single clock; clear restarts the count so a frame starts aligned.
 */
`timescale 1ns/1ps
module shc_tick_div
    import shc_pkg::*;
#(
    parameter int DIV = SCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic clear_in,
    // Tick
    output logic tick_out
);
    logic [15:0] count;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= 16'h0000;
            tick_out <= 1'b0;
        end else if (clear_in) begin
            count <= 16'h0000;
            tick_out <= 1'b0;
        end else if (count == 16'(DIV - 1)) begin
            count <= 16'h0000;
            tick_out <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            tick_out <= 1'b0;
        end
    end
endmodule

// ---- hw/shc_device.sv ----
/*
 * Transceiver control port: serial register access, alarm interrupt,
 * master reset filter and loopback / loop-timing selection.
 * Assumes serial pins are synchronous to clk_in and the serial clock
 * half period is at least two clk_in cycles.
 */
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module shc_device
    import shc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial control pins
    shc_if.dev port,
    // Mode and level control pins
    input wire logic host_or_pin_mode_select_in,
    input wire logic serial_remote_loop_en_in,
    input wire logic parallel_remote_loop_en_in,
    input wire logic digital_local_loop_en_in,
    input wire logic loop_timing_dejitter_en_in,
    input wire logic loop_timing_direct_en_in,
    input wire logic loop_timing_div32_in,
    // Alarm status from the datapath
    input wire logic [DATA_W-1:0] alarm_status_in,
    // Datapath selects
    output logic [1:0] tx_serial_src_out,
    output logic tx_par_ignore_out,
    output logic rx_par_from_tx_out,
    output logic rx_serial_ignore_out,
    output logic dejitter_ref_recovered_out,
    output logic [1:0] cmu_ref_sel_out
);
    // ********************************
    // Register storage
    // ********************************
    logic [DATA_W-1:0] regs [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] alarm_prev;
    logic [15:0] frame;
    logic [4:0] rise_cnt;
    logic [DATA_W-1:0] rd_shift;
    logic sclk_prev;
    logic [8:0] mrst_cnt;
    logic soft_reset;
    logic host_mode;
    logic frame_on;
    logic sclk_rise;
    logic sclk_fall;
    logic do_write;
    logic status_read;
    logic alarm_change;
    logic [5:0] ctrl;
    logic [DATA_W-1:0] rd_value;

    function automatic logic [DATA_W-1:0] reg_value(input logic [ADDR_W-1:0] a,
                                                    input logic [DATA_W-1:0] stored,
                                                    input logic [DATA_W-1:0] alarms);
        reg_value = (a == REG_ALARM_STATUS) ? alarms : stored;
    endfunction

    // ********************************
    // Mode and frame qualification
    // ********************************
    assign host_mode = host_or_pin_mode_select_in;
    assign frame_on = host_mode && !port.chip_sel_n;
    assign sclk_rise = frame_on && port.ser_clk && !sclk_prev;
    assign sclk_fall = frame_on && !port.ser_clk && sclk_prev;
    // Write commits on the sixteenth rise; extra clocks are ignored
    assign do_write = sclk_rise && (rise_cnt == 5'(FRAME_CLKS - 1)) && (frame[RW_POS] != RW_READ);
    assign status_read = sclk_fall && (rise_cnt == 5'(FIRST_READ_FALL)) && (frame[RW_POS] == RW_READ)
        && (frame[ADDR_LSB_POS +: ADDR_W] == REG_ALARM_STATUS);
    assign alarm_change = |(alarm_status_in ^ alarm_prev);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= port.ser_clk;
        end
    end

    // ********************************
    // Master reset filter
    // ********************************
    // Short glitches on the reset pin never disturb the registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mrst_cnt <= 9'h000;
        end else if (port.master_reset_n) begin
            mrst_cnt <= 9'h000;
        end else if (mrst_cnt <= 9'(RESET_MIN_CYC)) begin
            mrst_cnt <= mrst_cnt + 9'h001;
        end
    end
    assign soft_reset = (mrst_cnt > 9'(RESET_MIN_CYC));

    // ********************************
    // Serial frame capture
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rise_cnt <= 5'h00;
        end else if (!frame_on) begin
            rise_cnt <= 5'h00;
        end else if (sclk_rise && rise_cnt != 5'(FRAME_CLKS + 1)) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // Bit k of frame holds the bit taken on rise k+1
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame <= 16'h0000;
        end else if (sclk_rise && rise_cnt < 5'(FRAME_CLKS)) begin
            frame[rise_cnt[3:0]] <= port.serial_write;
        end
    end

    // ********************************
    // Register file
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < (1 << ADDR_W); i++) begin
                regs[i] <= REG_RESET_VAL;
            end
        end else if (soft_reset) begin
            for (int i = 0; i < (1 << ADDR_W); i++) begin
                regs[i] <= REG_RESET_VAL;
            end
        end else if (do_write && frame[ADDR_LSB_POS +: ADDR_W] != REG_ALARM_STATUS) begin
            // Dummy bit at position 7 is never looked at
            regs[frame[ADDR_LSB_POS +: ADDR_W]] <= {port.serial_write, frame[DATA_LSB_POS +: DATA_W-1]};
        end
    end

    // ********************************
    // Read data output
    // ********************************
    // Alarm bits come live from the datapath, never from storage
    assign rd_value = reg_value(frame[ADDR_LSB_POS +: ADDR_W], regs[frame[ADDR_LSB_POS +: ADDR_W]],
        alarm_status_in);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_shift <= 8'h00;
            port.serial_read <= 1'b0;
        end else if (sclk_fall && frame[RW_POS] == RW_READ) begin
            if (rise_cnt == 5'(FIRST_READ_FALL)) begin
                rd_shift <= rd_value >> 1;
                port.serial_read <= rd_value[0];
            end else if (rise_cnt > 5'(FIRST_READ_FALL) && rise_cnt <= 5'(LAST_READ_FALL)) begin
                rd_shift <= rd_shift >> 1;
                port.serial_read <= rd_shift[0];
            end
        end
    end

    // ********************************
    // Alarm interrupt
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_prev <= 8'h00;
        end else begin
            alarm_prev <= alarm_status_in;
        end
    end

    // A change in the same cycle as the status read keeps the line low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            port.int_oe <= 1'b0;
        end else if (!host_mode || soft_reset) begin
            port.int_oe <= 1'b0;
        end else if (alarm_change) begin
            port.int_oe <= 1'b1;
        end else if (status_read) begin
            port.int_oe <= 1'b0;
        end
    end

    // ********************************
    // Loopback and loop-timing selection
    // ********************************
    always_comb begin
        if (host_mode) begin
            ctrl = regs[REG_LOOP_CTRL][5:0];
        end else begin
            ctrl = {loop_timing_div32_in, loop_timing_direct_en_in, loop_timing_dejitter_en_in,
                digital_local_loop_en_in, parallel_remote_loop_en_in, serial_remote_loop_en_in};
        end
    end

    // Serial remote wins if the controller breaks the exclusion with parallel remote
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_serial_src_out <= TXSRC_NORMAL;
            tx_par_ignore_out <= 1'b0;
        end else begin
            if (ctrl[LC_SERIAL_REMOTE]) begin
                tx_serial_src_out <= TXSRC_RX_SERIAL;
            end else if (ctrl[LC_PARALLEL_REMOTE]) begin
                tx_serial_src_out <= TXSRC_RECOVERED_PAR;
            end else begin
                tx_serial_src_out <= TXSRC_NORMAL;
            end
            tx_par_ignore_out <= ctrl[LC_SERIAL_REMOTE] | ctrl[LC_PARALLEL_REMOTE];
        end
    end

    // Dual loop: serial input still feeds the serial remote loop while local loop runs
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_par_from_tx_out <= 1'b0;
            rx_serial_ignore_out <= 1'b0;
        end else begin
            rx_par_from_tx_out <= ctrl[LC_DIGITAL_LOCAL];
            rx_serial_ignore_out <= ctrl[LC_DIGITAL_LOCAL] & ~ctrl[LC_SERIAL_REMOTE];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dejitter_ref_recovered_out <= 1'b0;
            cmu_ref_sel_out <= REF_EXTERNAL;
        end else begin
            dejitter_ref_recovered_out <= ctrl[LC_DEJITTER];
            if (ctrl[LC_DIRECT]) begin
                cmu_ref_sel_out <= ctrl[LC_DIV32] ? REF_REC_DIV32 : REF_REC_DIV16;
            end else begin
                cmu_ref_sel_out <= REF_EXTERNAL;
            end
        end
    end
endmodule

// ---- hw/shc_host.sv ----
/*
 * Serial controller: takes register orders over Avalon-MM and runs one
 * sixteen-clock frame per order, plus timed master reset pulses.
 * Assumes the device samples its pins on the same clk_in.
 */
`timescale 1ns/1ps
module shc_host
    import shc_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int RESET_CYC = RESET_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Serial control pins
    shc_if.host port
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SHIFT = 4'b0010,
        ST_GAP = 4'b0100,
        ST_RESET = 4'b1000
    } shc_state_e;

    shc_state_e state;
    logic tick;
    logic [4:0] edge_cnt;
    logic [15:0] tx_shift;
    logic [DATA_W-1:0] rdata;
    logic [15:0] rst_cnt;
    logic req;
    logic busy;
    logic accept;
    logic start_frame;
    logic start_reset;

    assign req = avs_read_in | avs_write_in;
    assign busy = (state != ST_IDLE);
    // Writes to any address but status stall on waitrequest while a frame or reset pulse runs; reads are still accepted
    assign accept = req && avs_waitrequest_out && !(avs_write_in && busy && avs_address_in != AV_STATUS);
    assign start_frame = accept && avs_write_in && avs_address_in == AV_CMD;
    assign start_reset = accept && avs_write_in && avs_address_in == AV_RESET && avs_writedata_in[0];

    shc_tick_div #(.DIV(HALF_CYC)) u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .clear_in(state == ST_IDLE),
        .tick_out(tick)
    );

    // ********************************
    // Avalon slave
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= !accept;
            if (accept && avs_read_in) begin
                if (avs_address_in == AV_STATUS) begin
                    avs_readdata_out <= {16'h0000, rdata, 6'h00, ~port.int_n, busy};
                end else begin
                    avs_readdata_out <= 32'h0000_0000;
                end
            end
        end
    end

    // ********************************
    // Frame sequencer
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            edge_cnt <= 5'h00;
            tx_shift <= 16'h0000;
            rst_cnt <= 16'h0000;
            rdata <= 8'h00;
            port.chip_sel_n <= 1'b1;
            port.ser_clk <= 1'b0;
            port.serial_write <= 1'b0;
            port.master_reset_n <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start_frame) begin
                        // Read/write bit first, then address, dummy and data, each LSB first
                        tx_shift <= {1'b0, avs_writedata_in[CMD_WDATA_LSB +: DATA_W], 1'b0,
                            avs_writedata_in[CMD_ADDR_LSB +: ADDR_W]};
                        port.serial_write <= avs_writedata_in[CMD_READ_BIT];
                        port.chip_sel_n <= 1'b0;
                        edge_cnt <= 5'h00;
                        state <= ST_SHIFT;
                    end else if (start_reset) begin
                        port.master_reset_n <= 1'b0;
                        rst_cnt <= 16'h0000;
                        state <= ST_RESET;
                    end
                end
                ST_SHIFT: begin
                    if (tick && !port.ser_clk) begin
                        port.ser_clk <= 1'b1;
                        edge_cnt <= edge_cnt + 5'h01;
                        if (edge_cnt >= 5'(FIRST_READ_RISE - 1)) begin
                            rdata <= {port.serial_read, rdata[DATA_W-1:1]};
                        end
                    end else if (tick) begin
                        port.ser_clk <= 1'b0;
                        if (edge_cnt == 5'(FRAME_CLKS)) begin
                            state <= ST_GAP;
                        end else begin
                            port.serial_write <= tx_shift[0];
                            tx_shift <= tx_shift >> 1;
                        end
                    end
                end
                ST_GAP: begin
                    // Chip select stays high a full half period between frames
                    if (tick && !port.chip_sel_n) begin
                        port.chip_sel_n <= 1'b1;
                    end else if (tick) begin
                        state <= ST_IDLE;
                    end
                end
                ST_RESET: begin
                    if (rst_cnt == 16'(RESET_CYC - 1)) begin
                        port.master_reset_n <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        rst_cnt <= rst_cnt + 16'h0001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- tb/shc_chk.sv ----
/*
 * Link checker between serial host and device.
 * Assumes one clk_in domain and default HALF_CYC and RESET_CYC.
 */
`timescale 1ns/1ps
module shc_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link
    input wire logic chip_sel_n,
    input wire logic ser_clk,
    input wire logic serial_write,
    input wire logic serial_read,
    input wire logic master_reset_n,
    input wire logic int_oe
);
    // ********************************
    // Serial clock rises in a frame
    // ********************************
    logic [4:0] rises;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rises <= 5'h0;
        end else if (chip_sel_n) begin
            rises <= 5'h0;
        end else if ($rose(ser_clk)) begin
            rises <= rises + 5'h1;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ********************************
    // Properties
    // ********************************
    a_clk_in_frame: assert property ($rose(ser_clk) |-> !chip_sel_n)
        else $error("clock outside frame");
    a_half_period: assert property ($rose(ser_clk) |-> ser_clk[*4] ##1 !ser_clk)
        else $error("bad clock high time");
    a_frame_length: assert property ($rose(chip_sel_n) |-> rises == 5'h10)
        else $error("frame not 16 clocks");
    a_select_gap: assert property ($rose(chip_sel_n) |-> chip_sel_n[*4])
        else $error("select gap short");
    a_write_setup: assert property ($rose(ser_clk) |-> $stable(serial_write))
        else $error("write data moved at rise");
    a_read_on_fall: assert property ($changed(serial_read) |-> !ser_clk)
        else $error("read data moved while high");
    a_int_release: assert property ($fell(int_oe) |-> !chip_sel_n || !master_reset_n)
        else $error("interrupt freed unread");
    a_reset_pulse: assert property ($fell(master_reset_n) |-> ##252 !master_reset_n ##[1:8] master_reset_n)
        else $error("reset pulse length");
endmodule

// ---- tb/testbench.sv ----
/*
 * Bench: Avalon orders to the host, host and device joined by the link.
 * Assumes default HALF_CYC and RESET_CYC and a 25 MHz clk_in.
 */
`timescale 1ns/1ps
`define CHK(g, w) begin checks++; if ((g) !== (w)) begin err_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
module testbench
    import shc_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] av_addr = 4'h0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0000_0000;
    logic [31:0] av_rdata, s;
    logic av_wait;
    logic mode = 1'b0;
    logic [5:0] pins = 6'h00;
    logic [5:0] ctl;
    logic [7:0] alarm = 8'h00;
    logic [7:0] q, want;
    logic [15:0] cap_w, cap_r;
    logic sclk_q = 1'b0;
    wire [7:0] sel;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    // Loop control bits, then {src, par_ign, rx_loop, ser_ign, dejit, ref}; no row mixes remote loops
    logic [13:0] rows [8] = '{14'h0000, 14'h0160, 14'h02A0, 14'h0418, 14'h0570, 14'h0804, 14'h1001, 14'h3002};
    shc_if link();
    shc_host u_shc_host (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(av_addr), .avs_read_in(av_rd),
        .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
        .avs_waitrequest_out(av_wait), .port(link.host));
    shc_device u_shc_device (.clk_in(clk_in), .rst_in(rst_in), .port(link.dev), .host_or_pin_mode_select_in(mode),
        .serial_remote_loop_en_in(pins[0]), .parallel_remote_loop_en_in(pins[1]),
        .digital_local_loop_en_in(pins[2]), .loop_timing_dejitter_en_in(pins[3]),
        .loop_timing_direct_en_in(pins[4]), .loop_timing_div32_in(pins[5]), .alarm_status_in(alarm),
        .tx_serial_src_out(sel[7:6]), .tx_par_ignore_out(sel[5]), .rx_par_from_tx_out(sel[4]),
        .rx_serial_ignore_out(sel[3]), .dejitter_ref_recovered_out(sel[2]), .cmu_ref_sel_out(sel[1:0]));
    shc_chk u_shc_chk (.clk_in(clk_in), .rst_in(rst_in), .chip_sel_n(link.chip_sel_n), .ser_clk(link.ser_clk),
        .serial_write(link.serial_write), .serial_read(link.serial_read),
        .master_reset_n(link.master_reset_n), .int_oe(link.int_oe));
    initial forever #20 clk_in = ~clk_in;
    // Sampled mid-cycle so the link flops have settled
    always @(negedge clk_in) begin
        sclk_q <= link.ser_clk;
        if (!link.chip_sel_n && link.ser_clk && !sclk_q) begin
            cap_w <= {link.serial_write, cap_w[15:1]};
            cap_r <= {link.serial_read, cap_r[15:1]};
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Request holds until the edge that sees waitrequest low; only the cycle ceiling ends a hang
    task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_in);
        av_addr <= a;
        av_wr <= w;
        av_rd <= !w;
        av_wdata <= d;
        do begin
            @(posedge clk_in);
        end while (av_wait !== 1'b0);
        s = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic idle;
        do begin
            av(AV_STATUS, 1'b0, 32'h0000_0000);
        end while (s[ST_BUSY] !== 1'b0);
        q = s[15:8];
    endtask
    task automatic op(input logic r, input logic [5:0] a, input logic [7:0] d);
        av(AV_CMD, 1'b1, {15'h0000, r, 2'h0, a, d});
        idle();
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        `CHK({link.chip_sel_n, link.int_n, link.master_reset_n, sel}, 11'h700)
        for (int i = 0; i < 8; i++) begin
            {ctl, want} = rows[i];
            @(posedge clk_in);
            mode <= 1'b1;
            pins <= ~ctl;
            op(1'b0, REG_LOOP_CTRL, {2'h0, ctl});
            `CHK(cap_w & 16'hFF7F, {2'h0, ctl, 1'b0, REG_LOOP_CTRL, 1'b0})
            settle();
            `CHK(sel, want)
            @(posedge clk_in);
            mode <= 1'b0;
            pins <= ctl;
            op(1'b0, REG_LOOP_CTRL, {2'h0, ~ctl});
            settle();
            `CHK(sel, want)
        end
        @(posedge clk_in);
        mode <= 1'b1;
        op(1'b1, REG_LOOP_CTRL, 8'h00);
        `CHK(q, 8'h30)
        `CHK({cap_r[15:8], cap_w[6:0]}, {8'h30, REG_LOOP_CTRL, RW_READ})
        op(1'b0, 6'h3F, 8'hA5);
        op(1'b1, 6'h3F, 8'h00);
        `CHK(q, 8'hA5)
        @(posedge clk_in);
        alarm <= 8'h11;
        settle();
        `CHK(link.int_n, 1'b0)
        av(AV_STATUS, 1'b0, 32'h0000_0000);
        `CHK(s[ST_INT], 1'b1)
        op(1'b1, REG_ALARM_STATUS, 8'h00);
        `CHK({q, link.int_n}, 9'h023)
        @(posedge clk_in);
        mode <= 1'b0;
        alarm <= 8'h22;
        settle();
        `CHK(link.int_n, 1'b1)
        @(posedge clk_in);
        mode <= 1'b1;
        av(AV_RESET, 1'b1, 32'h0000_0001);
        idle();
        op(1'b1, 6'h3F, 8'h00);
        `CHK(q, REG_RESET_VAL)
        settle();
        `CHK(sel, 8'h00)
        av(4'hC, 1'b0, 32'h0000_0000);
        `CHK(s, 32'h0000_0000)
        conclude();
    end
endmodule
